// ==== core/nidpl_top.sv ====
// Node identifier pin loader: samples input pins once at power-up and builds the node identifier.
`include "nidpl_defs.svh"

module nidpl_top #(
    parameter int NUM_PINS = 16,
    parameter int ID_BITS  = 7
) (
    input  wire logic                          sys_clk,
    input  wire logic                          rst,
    input  wire logic                          ce,
    input  wire logic                          startup_go,
    input  wire logic [NUM_PINS-1:0]           gpin,
    input  wire logic [`NIDPL_COUNT_W-1:0]     id_pin_count,
    input  wire logic [`NIDPL_NETOPT_W-1:0]    net_options,
    input  wire logic [`NIDPL_AXIS_SEL_W-1:0]  axis_index,
    input  wire logic                          map_wr_en,
    input  wire logic [`NIDPL_MAP_W-1:0]       map_wr_data,
    output logic      [`NIDPL_MAP_W-1:0]       map_rd_data,
    output logic      [ID_BITS-1:0]            node_id,
    output logic                               node_id_valid,
    output logic                               pins_released
);

    ////////////////////////////////////////////////////////////////////////////////
    // Parameter checks, made at elaboration so that a bad size never reaches a netlist.
    // Sizes past seven identifier bits or sixteen pin numbers have no field to serve them.
    if (ID_BITS < 1 || ID_BITS > `NIDPL_ID_MAX_BITS) begin : g_bad_id_bits
        $error("nidpl_top: ID_BITS out of range");
    end
    if (NUM_PINS < ID_BITS || NUM_PINS > `NIDPL_PIN_SPACE) begin : g_bad_num_pins
        $error("nidpl_top: NUM_PINS out of range");
    end

    localparam logic [4:0] NUM_PINS_W = 5'(NUM_PINS);

    ////////////////////////////////////////////////////////////////////////////////
    // Mapping parameter, written by software at any time.
    // A write strobed while ce is low is lost, as is every other change of state.
    // The readback copy is a flop of its own so that the output comes straight from a register.
    logic [`NIDPL_MAP_W-1:0] node_id_pin_map;
    logic [`NIDPL_MAP_W-1:0] next_node_id_pin_map;

    always_comb begin
        next_node_id_pin_map = node_id_pin_map;
        if (map_wr_en) begin
            next_node_id_pin_map = map_wr_data;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            node_id_pin_map <= `NIDPL_MAP_RESET;
            map_rd_data     <= `NIDPL_MAP_RESET;
        end else if (ce) begin
            node_id_pin_map <= next_node_id_pin_map;
            map_rd_data     <= next_node_id_pin_map;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Startup sequence: wait for the go pulse, snapshot, build, then stay done for good.
    // The snapshot is taken in one cycle so that pins and settings are seen together.
    // Settings are copied with the pins so that a write after the sample cannot leak in.
    nidpl_pkg::nidpl_state_t state;
    nidpl_pkg::nidpl_state_t next_state;

    logic [`NIDPL_PIN_SPACE-1:0]  snap_pins;
    logic [`NIDPL_PIN_SPACE-1:0]  next_snap_pins;
    logic [`NIDPL_MAP_W-1:0]      snap_map;
    logic [`NIDPL_MAP_W-1:0]      next_snap_map;
    logic [`NIDPL_COUNT_W-1:0]    snap_count;
    logic [`NIDPL_COUNT_W-1:0]    next_snap_count;
    logic                         snap_multi;
    logic                         next_snap_multi;
    logic [`NIDPL_AXIS_SEL_W-1:0] snap_axis;
    logic [`NIDPL_AXIS_SEL_W-1:0] next_snap_axis;
    logic [ID_BITS-1:0]           next_node_id;
    logic                         next_node_id_valid;
    logic                         next_pins_released;
    logic [ID_BITS-1:0]           pin_id;
    logic [ID_BITS-1:0]           axis_id;

    always_comb begin
        next_state      = state;
        next_snap_pins  = snap_pins;
        next_snap_map   = snap_map;
        next_snap_count = snap_count;
        next_snap_multi = snap_multi;
        next_snap_axis  = snap_axis;
        case (state)
            nidpl_pkg::st_wait: begin
                if (startup_go) begin
                    next_state = nidpl_pkg::st_sample;
                end
            end
            nidpl_pkg::st_sample: begin
                next_snap_pins  = `NIDPL_PIN_SPACE'(gpin);
                next_snap_map   = node_id_pin_map;
                next_snap_count = id_pin_count;
                next_snap_multi = net_options[`NIDPL_NETOPT_MULTI];
                next_snap_axis  = axis_index;
                next_state      = nidpl_pkg::st_build;
            end
            nidpl_pkg::st_build: begin
                next_state = nidpl_pkg::st_done;
            end
            nidpl_pkg::st_done: begin
                next_state = nidpl_pkg::st_done;
            end
            default: begin
                next_state = nidpl_pkg::st_wait;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state      <= nidpl_pkg::st_wait;
            snap_pins  <= '0;
            snap_map   <= `NIDPL_MAP_RESET;
            snap_count <= '0;
            snap_multi <= 1'b0;
            snap_axis  <= '0;
        end else if (ce) begin
            state      <= next_state;
            snap_pins  <= next_snap_pins;
            snap_map   <= next_snap_map;
            snap_count <= next_snap_count;
            snap_multi <= next_snap_multi;
            snap_axis  <= next_snap_axis;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Identifier outputs: loaded once from the build state and then held until reset.
    // Only reset clears them, so a later go pulse or pin change cannot disturb them.
    always_comb begin
        next_node_id       = node_id;
        next_node_id_valid = node_id_valid;
        next_pins_released = pins_released;
        if (state == nidpl_pkg::st_build) begin
            if (snap_multi) begin
                next_node_id = axis_id;
            end else begin
                next_node_id = pin_id;
            end
            next_node_id_valid = 1'b1;
            next_pins_released = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            node_id       <= '0;
            node_id_valid <= 1'b0;
            pins_released <= 1'b0;
        end else if (ce) begin
            node_id       <= next_node_id;
            node_id_valid <= next_node_id_valid;
            pins_released <= next_pins_released;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Multi-axis layout: one identifier per byte, selected by this axis.
    // The two-bit axis index reaches byte three at most, so the slice never leaves the map.
    always_comb begin
        axis_id = snap_map[snap_axis*`NIDPL_AXIS_STRIDE +: ID_BITS];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin-based identifier, one selector and one pin multiplexer per identifier bit.
    // Pin fields end at bit 27, so bits 28 to 30 are read only by the multi-axis slice.
    logic map_enabled;

    always_comb begin
        map_enabled = snap_map[`NIDPL_MAP_EN_BIT];
    end

    for (genvar i = 0; i < ID_BITS; i++) begin : g_bit
        logic [4:0]                default_pin;
        logic [`NIDPL_FIELD_W-1:0] pin_sel;
        logic                      bit_used;
        logic                      pin_ok;

        // A pin number past the last fitted pin reads zero, also when N exceeds the pins.
        // The selector is chosen before the range test so both mappings share one guard.
        always_comb begin
            default_pin = NUM_PINS_W - {2'b00, snap_count} + 5'(i);
            bit_used    = (5'(i) < {2'b00, snap_count});
            if (map_enabled) begin
                pin_sel = snap_map[i*`NIDPL_FIELD_W +: `NIDPL_FIELD_W];
            end else begin
                pin_sel = default_pin[`NIDPL_FIELD_W-1:0];
            end
            pin_ok = ({1'b0, pin_sel} < NUM_PINS_W);
        end

        nidpl_bit_mux u_mux (
            .pins    (snap_pins),
            .sel     (pin_sel),
            .enable  (bit_used & pin_ok),
            .bit_out (pin_id[i])
        );
    end

endmodule // nidpl_top

// ==== core/nidpl_defs.svh ====
// Offsets, field positions, widths and reset values of the node identifier pin loader.
`ifndef NIDPL_DEFS_SVH
`define NIDPL_DEFS_SVH

`define NIDPL_MAP_W          32
`define NIDPL_MAP_RESET      32'h00000000
`define NIDPL_MAP_EN_BIT     31
`define NIDPL_FIELD_W        4
`define NIDPL_PIN_SPACE      16
`define NIDPL_NETOPT_W       16
`define NIDPL_NETOPT_MULTI   3
`define NIDPL_AXIS_STRIDE    8
`define NIDPL_AXIS_SEL_W     2
`define NIDPL_COUNT_W        3
`define NIDPL_ID_MAX_BITS    7

`endif

// ==== core/nidpl_pkg.sv ====
// Types shared by the node identifier pin loader.
package nidpl_pkg;

    typedef enum logic [1:0] {
        st_wait,
        st_sample,
        st_build,
        st_done
    } nidpl_state_t;

endpackage

// ==== core/nidpl_bit_mux.sv ====
// One identifier bit picked from the captured pin levels by a four-bit pin number.
`include "nidpl_defs.svh"

module nidpl_bit_mux (
    input  wire logic [`NIDPL_PIN_SPACE-1:0] pins,
    input  wire logic [`NIDPL_FIELD_W-1:0]   sel,
    input  wire logic                        enable,
    output logic                             bit_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // A disabled bit reads zero whatever its selector holds.
    always_comb begin
        bit_out = enable & pins[sel];
    end

endmodule // nidpl_bit_mux

// ==== sim/nidpl_monitor.sv ====
// Concurrent checks on the ports of the node identifier pin loader.
module nidpl_monitor #(
    parameter int NUM_PINS = 16,
    parameter int ID_BITS  = 7
) (
    input wire logic                sys_clk,
    input wire logic                rst,
    input wire logic                ce,
    input wire logic                startup_go,
    input wire logic [NUM_PINS-1:0] gpin,
    input wire logic [2:0]          id_pin_count,
    input wire logic [15:0]         net_options,
    input wire logic [1:0]          axis_index,
    input wire logic                map_wr_en,
    input wire logic [31:0]         map_wr_data,
    input wire logic [31:0]         map_rd_data,
    input wire logic [ID_BITS-1:0]  node_id,
    input wire logic                node_id_valid,
    input wire logic                pins_released
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    a_valid_holds: assert property (node_id_valid |=> node_id_valid)
        else $error("valid dropped");
    a_id_frozen: assert property (node_id_valid |=> $stable(node_id))
        else $error("identifier moved after capture");
    a_release_tracks: assert property (pins_released == node_id_valid)
        else $error("release differs from valid");
    a_id_zero_early: assert property (!node_id_valid |-> node_id == '0)
        else $error("identifier shown before capture");
    // The build takes a fixed short pipeline, so a late or early valid means a missed sample.
    a_build_latency: assert property ($rose(node_id_valid) |->
        $past(startup_go, 2) || $past(startup_go, 3))
        else $error("valid without a recent start");
    a_map_readback: assert property (ce && map_wr_en |=> map_rd_data == $past(map_wr_data))
        else $error("map write not stored");
    a_map_hold: assert property (!(ce && map_wr_en) |=> $stable(map_rd_data))
        else $error("map changed without write");
    a_ce_freeze: assert property (!ce |=> $stable(node_id) && $stable(node_id_valid))
        else $error("state moved while frozen");
endmodule // nidpl_monitor

bind nidpl_top nidpl_monitor #(.NUM_PINS(NUM_PINS), .ID_BITS(ID_BITS)) u_mon (.sys_clk, .rst,
    .ce, .startup_go, .gpin, .id_pin_count, .net_options, .axis_index, .map_wr_en,
    .map_wr_data, .map_rd_data, .node_id, .node_id_valid, .pins_released);

// ==== sim/nidpl_pin_model.sv ====
// Input pin model: steady levels until release, then reused traffic.
module nidpl_pin_model (
    input  wire logic        sys_clk,
    input  wire logic [15:0] pin_pattern,
    input  wire logic        pins_released,
    output logic      [15:0] gpin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] reuse_level = 16'h0000;
    always @(posedge sys_clk) begin
        reuse_level <= ~reuse_level ^ pin_pattern;
    end
    // Released pins with a zero pattern bit toggle every cycle, so a late sample of those pins corrupts the identifier.
    assign gpin = pins_released ? reuse_level : pin_pattern;
endmodule // nidpl_pin_model

// ==== sim/testbench.sv ====
// Testbench: one startup capture per reset over a table of mappings.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic        startup_go = 1'b0;
    logic [15:0] gpin;
    logic [15:0] pin_pattern = 16'h0000;
    logic [2:0]  id_pin_count = 3'h0;
    logic [15:0] net_options = 16'h0000;
    logic [1:0]  axis_index = 2'h0;
    logic        map_wr_en = 1'b0;
    logic [31:0] map_wr_data = 32'h00000000;
    logic [31:0] map_rd_data;
    logic [6:0]  node_id;
    logic        node_id_valid;
    logic        pins_released;
    int          error_cnt = 0;
    int          checks = 0;
    always #5 sys_clk = ~sys_clk;
    nidpl_top dut (.sys_clk, .rst, .ce, .startup_go, .gpin, .id_pin_count, .net_options,
        .axis_index, .map_wr_en, .map_wr_data, .map_rd_data, .node_id, .node_id_valid,
        .pins_released);
    nidpl_pin_model pins (.sys_clk, .pin_pattern, .pins_released, .gpin);
    ////////////////////////////////////////
    task automatic tick(int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic check(string what, logic [31:0] exp, logic [31:0] seen);
        checks++;
        if (exp !== seen) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        if (error_cnt == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic write_map(logic [31:0] value, logic enable, logic [31:0] exp);
        ce = enable;
        map_wr_en = 1'b1;
        map_wr_data = value;
        tick(1);
        ce = 1'b1;
        map_wr_en = 1'b0;
        check("map_rd_data", exp, map_rd_data);
        tick(1);
    endtask
    // Each case resets the block, so a second reset in mid-run is exercised by every case after the first.
    task automatic run(logic [31:0] map, logic [2:0] cnt, logic [15:0] opt, logic [1:0] axis,
                       logic [15:0] pat, logic [6:0] exp);
        int n;
        rst = 1'b1;
        tick(8);
        rst = 1'b0;
        id_pin_count = cnt;
        net_options = opt;
        axis_index = axis;
        pin_pattern = pat;
        write_map(map, 1'b1, map);
        write_map(~map, 1'b0, map);
        startup_go = 1'b1;
        tick(1);
        startup_go = 1'b0;
        n = 0;
        while (node_id_valid !== 1'b1 && n < 20) begin
            tick(1);
            n++;
        end
        if (n == 20) begin
            error_cnt++;
            wrap_up();
        end
        check("node_id", {25'h0, exp}, {25'h0, node_id});
        check("valid latency", 32'h00000002, n);
        check("pins_released", 32'h00000001, {31'h0, pins_released});
        write_map(~map, 1'b1, ~map);
        startup_go = 1'b1;
        tick(4);
        startup_go = 1'b0;
        check("late node_id", {25'h0, exp}, {25'h0, node_id});
    endtask
    initial begin
        run(32'h00000000, 3'h3, 16'h0000, 2'h0, 16'hA000, 7'h05);
        run(32'h00000000, 3'h7, 16'h0000, 2'h0, 16'h8200, 7'h41);
        run(32'h00000210, 3'h3, 16'h0000, 2'h0, 16'hA000, 7'h05);
        run(32'h80000210, 3'h3, 16'h0000, 2'h0, 16'h0006, 7'h06);
        run(32'hF6FEDCBA, 3'h7, 16'h0000, 2'h0, 16'h5440, 7'h55);
        run(32'hF6FEDCBA, 3'h2, 16'h0000, 2'h0, 16'h5440, 7'h01);
        run(32'h7F2A1355, 3'h5, 16'h0008, 2'h2, 16'hFFFF, 7'h2A);
        run(32'hD5000000, 3'h7, 16'h0008, 2'h3, 16'h0000, 7'h55);
        wrap_up();
    end
endmodule // testbench
